// File: logic/svc_pkg.sv
// Overview of operation
// - Trap instruction sets flag bit 3 and jumps to supervisor address zero.
// - Trap entry pushes return PC and flags onto the stack like an interrupt.
// - Return from interrupt always clears flag bit 3 whatever was stacked.
// - Supervisor entry selects the service by table lookup on the accumulator.
// - Parameter block starts at F8h on 256-byte RAM, 78h on 128-byte RAM.
// - Service 00 calibrates, zeroes PC and SP, parameter block left undefined.
// - Service 06 takes table id in byte 2, returns eight table values.
// - Protect service sources from fixed address 00h or 80h by RAM variant.
// - Service 08 restores oscillator and reference trims, returns two zeros.
// - Reset loads the reference trim with its 5.0V factory value.
// - Reference trim: divider disable bit 7, trim 6:4, offset trim 3:0.
package svc_pkg;
	// Register indices; byte address is four times the index
	localparam logic [9:0] IDX_CTRL = 10'h000;
	localparam logic [9:0] IDX_STATUS = 10'h001;
	localparam logic [9:0] IDX_ACC = 10'h002;
	localparam logic [9:0] IDX_FLAGS = 10'h003;
	localparam logic [9:0] IDX_PC = 10'h004;
	localparam logic [9:0] IDX_SP = 10'h005;
	localparam logic [9:0] IDX_PROT = 10'h006;
	localparam logic [9:0] IDX_MAIN_OSC = 10'h007;
	localparam logic [9:0] IDX_SLOW_OSC = 10'h008;
	localparam logic [9:0] IDX_REF_TRIM = 10'h0EA;
	localparam logic [1:0] RAM_WINDOW = 2'h1;
	// Field positions
	localparam int CTRL_TRAP_BIT = 0;
	localparam int CTRL_CLR_ERR_BIT = 1;
	localparam int FLAG_SUPER_BIT = 3;
	localparam int REF_DIV_DIS_BIT = 7;
	localparam int REF_TEMP_MSB = 6;
	localparam int REF_TEMP_LSB = 4;
	localparam int REF_OFS_MSB = 3;
	localparam int REF_OFS_LSB = 0;
	// Service codes
	localparam logic [7:0] SVC_RESET = 8'h00;
	localparam logic [7:0] SVC_READ = 8'h01;
	localparam logic [7:0] SVC_WRITE = 8'h02;
	localparam logic [7:0] SVC_ERASE = 8'h03;
	localparam logic [7:0] SVC_PROTECT = 8'h04;
	localparam logic [7:0] SVC_TABLE = 8'h06;
	localparam logic [7:0] SVC_CSUM = 8'h07;
	localparam logic [7:0] SVC_CAL = 8'h08;
	// Memory layout
	localparam logic [7:0] PARAM_BASE_256 = 8'hF8;
	localparam logic [7:0] PARAM_BASE_128 = 8'h78;
	localparam logic [7:0] PROT_SRC_256 = 8'h80;
	localparam logic [7:0] PROT_SRC_128 = 8'h00;
	localparam logic [9:0] BLOCK_BYTES = 10'h040;
	localparam logic [9:0] PROT_BYTES = 10'h002;
	localparam logic [9:0] TABLE_BYTES = 10'h008;
	localparam logic [7:0] FLASH_BLOCKS = 8'h08;
	localparam logic [9:0] CSUM_MAX = 10'h200;
	localparam logic [7:0] FLASH_ERASED = 8'h00;
	// Factory trims and table contents (values arbitrary)
	localparam logic [7:0] REF_TRIM_5V = 8'h48;
	localparam logic [7:0] REF_TRIM_3V3 = 8'h46;
	localparam logic [7:0] MAIN_OSC_5V = 8'h80;
	localparam logic [7:0] MAIN_OSC_3V3 = 8'h7C;
	localparam logic [7:0] SLOW_OSC_DEF = 8'h10;
	localparam logic [7:0] SILICON_ID1 = 8'h5A;
	localparam logic [7:0] SILICON_ID0 = 8'hA5;
	localparam logic [7:0] VERSION_CODE = 8'h11;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_PUSH_PCH = 4'h1,
		ST_PUSH_PCL = 4'h2,
		ST_PUSH_F = 4'h3,
		ST_DISPATCH = 4'h4,
		ST_LOOP = 4'h5,
		ST_RES0 = 4'h6,
		ST_RES1 = 4'h7,
		ST_POP_F = 4'h8,
		ST_POP_PCL = 4'h9,
		ST_POP_PCH = 4'hA
	} svc_state_t;
endpackage

// File: logic/svc_flash.sv
`timescale 1ns/1ps
module svc_flash (
	// Clock
	input wire logic clk,
	// Write port
	input wire logic wr_en,
	input wire logic [8:0] wr_addr,
	input wire logic [7:0] wr_data,
	// Read port
	input wire logic [8:0] rd_addr,
	output logic [7:0] rd_data
);
	// Eight 64-byte blocks; asynchronous read keeps copies one byte a cycle
	logic [7:0] mem [0:511];

	assign rd_data = mem[rd_addr];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end
endmodule

// File: logic/svc_trim.sv
`timescale 1ns/1ps
module svc_trim (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Software write
	input wire logic wr_en,
	input wire logic [1:0] wr_sel,
	input wire logic [7:0] wr_data,
	// Calibration
	input wire logic restore,
	// Trim values
	output logic [7:0] main_osc_trim,
	output logic [7:0] slow_osc_trim,
	output logic [7:0] reference_trim
);
	// factory 5.0V reference value on reset and on restore
	always_ff @(posedge clk) begin
		if (!rst_n || restore) begin
			main_osc_trim <= svc_pkg::MAIN_OSC_5V;
			slow_osc_trim <= svc_pkg::SLOW_OSC_DEF;
			reference_trim <= svc_pkg::REF_TRIM_5V;
		end else if (wr_en) begin
			case (wr_sel)
				2'h0: main_osc_trim <= wr_data;
				2'h1: slow_osc_trim <= wr_data;
				default: reference_trim <= wr_data;
			endcase
		end
	end
endmodule

// File: logic/svc_dispatch.sv
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
module svc_dispatch #(
	parameter bit RAM_256 = 1'b1
) (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RST_N,
	// APB slave
	input wire logic [11:0] PADDR,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output wire logic PREADY,
	output wire logic PSLVERR,
	// Trim outputs
	output wire logic FLASH_DIVIDER_DISABLE,
	output wire logic [2:0] REFERENCE_TEMP_TRIM,
	output wire logic [3:0] REFERENCE_OFFSET_TRIM,
	output wire logic [7:0] MAIN_OSC_TRIM,
	output wire logic [7:0] SLOW_OSC_TRIM,
	// Status
	output wire logic SVC_BUSY
);
	// parameter block placement by RAM variant
	localparam logic [7:0] PARAM_BASE = RAM_256 ?
		svc_pkg::PARAM_BASE_256 : svc_pkg::PARAM_BASE_128;
	localparam logic [7:0] PROT_SRC = RAM_256 ?
		svc_pkg::PROT_SRC_256 : svc_pkg::PROT_SRC_128;

	svc_pkg::svc_state_t state_r, state_nxt;
	logic [7:0] ram [0:255];
	logic [7:0] acc_r, flags_r, sp_r, svc_r, blk_r, ptr_r;
	logic [15:0] pc_r, ret_pc_r, csum_r, prot_r;
	logic [9:0] cnt_r, lim_r;
	logic err_r;
	logic ram_we;
	logic [7:0] ram_wa, ram_wd;
	logic [7:0] fl_rd;
	logic [7:0] ref_trim;

	// second-level decode of the accumulator into a loop length
	function automatic logic [9:0] svc_limit(input logic [7:0] code,
			input logic [7:0] count);
		logic [9:0] len;
		len = 10'h000;
		case (code)
			svc_pkg::SVC_READ, svc_pkg::SVC_WRITE,
			svc_pkg::SVC_ERASE: len = svc_pkg::BLOCK_BYTES;
			svc_pkg::SVC_PROTECT: len = svc_pkg::PROT_BYTES;
			svc_pkg::SVC_TABLE: len = svc_pkg::TABLE_BYTES;
			svc_pkg::SVC_CSUM: len = (count > svc_pkg::FLASH_BLOCKS) ?
				svc_pkg::CSUM_MAX : {count[3:0], 6'h00};
			default: len = 10'h000;
		endcase
		return len;
	endfunction

	function automatic logic svc_valid(input logic [7:0] code);
		return code <= svc_pkg::SVC_CAL && code != 8'h05;
	endfunction

	// table 0 carries identity, table 1 the factory trims
	function automatic logic [7:0] table_value(input logic [7:0] tid,
			input logic [2:0] i);
		logic [7:0] v;
		v = 8'h00;
		if (tid == 8'h00) begin
			case (i)
				3'h0: v = svc_pkg::SILICON_ID1;
				3'h1: v = svc_pkg::SILICON_ID0;
				default: v = 8'h00;
			endcase
		end else if (tid == 8'h01) begin
			case (i)
				3'h0: v = svc_pkg::REF_TRIM_3V3;
				3'h1: v = svc_pkg::MAIN_OSC_3V3;
				3'h4: v = svc_pkg::REF_TRIM_5V;
				3'h5: v = svc_pkg::MAIN_OSC_5V;
				default: v = 8'h00;
			endcase
		end
		return v;
	endfunction

	// APB decode
	wire logic apb_setup = PSEL & ~PENABLE;
	wire logic apb_access = PSEL & PENABLE;
	wire logic apb_wr = apb_access & PWRITE;
	wire logic [9:0] reg_idx = PADDR[11:2];
	wire logic hit_ram = reg_idx[9:8] == svc_pkg::RAM_WINDOW;
	wire logic hit_ctrl = reg_idx == svc_pkg::IDX_CTRL;
	wire logic hit_stat = reg_idx == svc_pkg::IDX_STATUS;
	wire logic hit_acc = reg_idx == svc_pkg::IDX_ACC;
	wire logic hit_flags = reg_idx == svc_pkg::IDX_FLAGS;
	wire logic hit_pc = reg_idx == svc_pkg::IDX_PC;
	wire logic hit_sp = reg_idx == svc_pkg::IDX_SP;
	wire logic hit_prot = reg_idx == svc_pkg::IDX_PROT;
	wire logic hit_mosc = reg_idx == svc_pkg::IDX_MAIN_OSC;
	wire logic hit_sosc = reg_idx == svc_pkg::IDX_SLOW_OSC;
	wire logic hit_ref = reg_idx == svc_pkg::IDX_REF_TRIM;
	wire logic mapped = hit_ram | hit_ctrl | hit_stat | hit_acc |
		hit_flags | hit_pc | hit_sp | hit_prot | hit_mosc | hit_sosc |
		hit_ref;
	wire logic busy = state_r != svc_pkg::ST_IDLE;
	// CPU state is frozen while the supervisor runs; such writes are dropped
	wire logic cpu_wr = apb_wr & ~busy;
	wire logic trap_go = cpu_wr & hit_ctrl & PWDATA[svc_pkg::CTRL_TRAP_BIT];
	wire logic err_clr = apb_wr & hit_ctrl & PWDATA[svc_pkg::CTRL_CLR_ERR_BIT];
	wire logic trim_wr = apb_wr & (hit_mosc | hit_sosc | hit_ref);
	wire logic [1:0] trim_sel = hit_mosc ? 2'h0 : (hit_sosc ? 2'h1 : 2'h2);

	assign PREADY = 1'b1;
	assign PSLVERR = apb_access & ~mapped;
	assign SVC_BUSY = busy;

	// Engine decode
	wire logic in_disp = state_r == svc_pkg::ST_DISPATCH;
	wire logic in_loop = state_r == svc_pkg::ST_LOOP;
	wire logic is_read = svc_r == svc_pkg::SVC_READ;
	wire logic is_write = svc_r == svc_pkg::SVC_WRITE;
	wire logic is_erase = svc_r == svc_pkg::SVC_ERASE;
	wire logic is_prot = svc_r == svc_pkg::SVC_PROTECT;
	wire logic is_tab = svc_r == svc_pkg::SVC_TABLE;
	wire logic is_csum = svc_r == svc_pkg::SVC_CSUM;
	wire logic is_rst = svc_r == svc_pkg::SVC_RESET;
	// block index; buffer pointer from the parameter block
	wire logic [7:0] parm2 = ram[PARAM_BASE + 8'h02];
	wire logic [7:0] parm3 = ram[PARAM_BASE + 8'h03];
	wire logic [9:0] disp_lim = svc_limit(svc_r, parm2);
	wire logic loop_last = cnt_r == lim_r - 10'h001;
	// protect data always comes from the fixed source address
	wire logic [7:0] loop_src = is_prot ? PROT_SRC + cnt_r[7:0] :
		ptr_r + cnt_r[7:0];
	wire logic [7:0] src_byte = ram[loop_src];
	wire logic [7:0] pop_byte = ram[sp_r - 8'h01];
	wire logic [8:0] fl_addr = is_csum ? cnt_r[8:0] :
		{blk_r[2:0], cnt_r[5:0]};
	wire logic fl_we = in_loop & (is_write | is_erase);
	wire logic [7:0] fl_wd = is_erase ? svc_pkg::FLASH_ERASED : src_byte;
	// calibration (and reset, which calibrates first) restores trims
	wire logic trim_restore = in_disp & (svc_r == svc_pkg::SVC_CAL | is_rst);
	wire logic err_set = in_disp & ~svc_valid(svc_r);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			svc_pkg::ST_IDLE: begin
				if (trap_go) begin
					state_nxt = svc_pkg::ST_PUSH_PCH;
				end
			end
			svc_pkg::ST_PUSH_PCH: state_nxt = svc_pkg::ST_PUSH_PCL;
			svc_pkg::ST_PUSH_PCL: state_nxt = svc_pkg::ST_PUSH_F;
			svc_pkg::ST_PUSH_F: state_nxt = svc_pkg::ST_DISPATCH;
			svc_pkg::ST_DISPATCH: begin
				if (is_rst) begin
					state_nxt = svc_pkg::ST_IDLE;
				end else if (!svc_valid(svc_r)) begin
					state_nxt = svc_pkg::ST_POP_F;
				end else if (disp_lim != 10'h000) begin
					state_nxt = svc_pkg::ST_LOOP;
				end else begin
					state_nxt = svc_pkg::ST_RES0;
				end
			end
			svc_pkg::ST_LOOP: begin
				if (loop_last) begin
					state_nxt = is_tab ? svc_pkg::ST_POP_F : svc_pkg::ST_RES0;
				end
			end
			svc_pkg::ST_RES0: state_nxt = svc_pkg::ST_RES1;
			svc_pkg::ST_RES1: state_nxt = svc_pkg::ST_POP_F;
			svc_pkg::ST_POP_F: state_nxt = svc_pkg::ST_POP_PCL;
			svc_pkg::ST_POP_PCL: state_nxt = svc_pkg::ST_POP_PCH;
			svc_pkg::ST_POP_PCH: state_nxt = svc_pkg::ST_IDLE;
			default: state_nxt = svc_pkg::ST_IDLE;
		endcase
	end

	// Single RAM write port shared by software, stack and services
	always_comb begin
		ram_we = 1'b0;
		ram_wa = sp_r;
		ram_wd = 8'h00;
		case (state_r)
			svc_pkg::ST_IDLE: begin
				ram_we = cpu_wr & hit_ram;
				ram_wa = reg_idx[7:0];
				ram_wd = PWDATA[7:0];
			end
			// return PC then flags pushed as for an interrupt
			svc_pkg::ST_PUSH_PCH: begin
				ram_we = 1'b1;
				ram_wd = ret_pc_r[15:8];
			end
			svc_pkg::ST_PUSH_PCL: begin
				ram_we = 1'b1;
				ram_wd = ret_pc_r[7:0];
			end
			svc_pkg::ST_PUSH_F: begin
				ram_we = 1'b1;
				ram_wd = flags_r;
			end
			svc_pkg::ST_LOOP: begin
				ram_we = is_read | is_tab;
				ram_wa = is_tab ? PARAM_BASE + cnt_r[7:0] : loop_src;
				ram_wd = is_tab ? table_value(blk_r, cnt_r[2:0]) : fl_rd;
			end
			// checksum high then low; other services return zeros
			svc_pkg::ST_RES0: begin
				ram_we = 1'b1;
				ram_wa = PARAM_BASE;
				ram_wd = is_csum ? csum_r[15:8] : 8'h00;
			end
			svc_pkg::ST_RES1: begin
				ram_we = 1'b1;
				ram_wa = PARAM_BASE + 8'h01;
				ram_wd = is_csum ? csum_r[7:0] : 8'h00;
			end
			default: ram_we = 1'b0;
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (ram_we) begin
			ram[ram_wa] <= ram_wd;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			state_r <= svc_pkg::ST_IDLE;
			err_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			// A fault in the same cycle as the clear stays set
			err_r <= err_set | (err_r & ~err_clr);
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			acc_r <= 8'h00;
			flags_r <= 8'h00;
			pc_r <= 16'h0000;
			ret_pc_r <= 16'h0000;
			sp_r <= 8'h00;
			svc_r <= 8'h00;
		end else begin
			case (state_r)
				svc_pkg::ST_IDLE: begin
					if (cpu_wr & hit_acc) acc_r <= PWDATA[7:0];
					if (cpu_wr & hit_flags) flags_r <= PWDATA[7:0];
					if (cpu_wr & hit_pc) pc_r <= PWDATA[15:0];
					if (cpu_wr & hit_sp) sp_r <= PWDATA[7:0];
					// supervisor flag set, jump to ROM address zero
					if (trap_go) begin
						svc_r <= acc_r;
						ret_pc_r <= pc_r;
						pc_r <= 16'h0000;
						flags_r[svc_pkg::FLAG_SUPER_BIT] <= 1'b1;
					end
				end
				svc_pkg::ST_PUSH_PCH, svc_pkg::ST_PUSH_PCL,
				svc_pkg::ST_PUSH_F: sp_r <= sp_r + 8'h01;
				svc_pkg::ST_DISPATCH: begin
					// software reset leaves PC and SP at zero
					if (is_rst) begin
						pc_r <= 16'h0000;
						sp_r <= 8'h00;
						flags_r <= 8'h00;
					end
					if (is_tab) acc_r <= svc_pkg::VERSION_CODE;
				end
				// supervisor flag cleared whatever was stacked
				svc_pkg::ST_POP_F: begin
					flags_r <= pop_byte &
						~(8'h01 << svc_pkg::FLAG_SUPER_BIT);
					sp_r <= sp_r - 8'h01;
				end
				svc_pkg::ST_POP_PCL: begin
					pc_r[7:0] <= pop_byte;
					sp_r <= sp_r - 8'h01;
				end
				svc_pkg::ST_POP_PCH: begin
					pc_r[15:8] <= pop_byte;
					sp_r <= sp_r - 8'h01;
				end
				default: sp_r <= sp_r;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			blk_r <= 8'h00;
			ptr_r <= 8'h00;
			cnt_r <= 10'h000;
			lim_r <= 10'h000;
			csum_r <= 16'h0000;
			prot_r <= 16'h0000;
		end else if (in_disp) begin
			blk_r <= parm2;
			ptr_r <= parm3;
			cnt_r <= 10'h000;
			lim_r <= disp_lim;
			csum_r <= 16'h0000;
		end else if (in_loop) begin
			cnt_r <= cnt_r + 10'h001;
			if (is_csum) csum_r <= csum_r + {8'h00, fl_rd};
			if (is_prot && cnt_r[0]) prot_r[7:0] <= src_byte;
			if (is_prot && !cnt_r[0]) prot_r[15:8] <= src_byte;
		end
	end

	// Read data registered in the setup phase, answered with no wait
	wire logic [31:0] rd_val =
		hit_ram ? {24'h000000, ram[reg_idx[7:0]]} :
		hit_stat ? {24'h000000, state_r, 2'h0, err_r, busy} :
		hit_acc ? {24'h000000, acc_r} :
		hit_flags ? {24'h000000, flags_r} :
		hit_pc ? {16'h0000, pc_r} :
		hit_sp ? {24'h000000, sp_r} :
		hit_prot ? {16'h0000, prot_r} :
		hit_mosc ? {24'h000000, MAIN_OSC_TRIM} :
		hit_sosc ? {24'h000000, SLOW_OSC_TRIM} :
		hit_ref ? {24'h000000, ref_trim} : 32'h00000000;

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			PRDATA <= 32'h00000000;
		end else if (apb_setup && !PWRITE) begin
			PRDATA <= rd_val;
		end
	end

	svc_flash u_flash (
		.clk(SYS_CLK),
		.wr_en(fl_we),
		.wr_addr(fl_addr),
		.wr_data(fl_wd),
		.rd_addr(fl_addr),
		.rd_data(fl_rd)
	);

	svc_trim u_trim (
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.wr_en(trim_wr),
		.wr_sel(trim_sel),
		.wr_data(PWDATA[7:0]),
		.restore(trim_restore),
		.main_osc_trim(MAIN_OSC_TRIM),
		.slow_osc_trim(SLOW_OSC_TRIM),
		.reference_trim(ref_trim)
	);

	assign FLASH_DIVIDER_DISABLE = ref_trim[svc_pkg::REF_DIV_DIS_BIT];
	assign REFERENCE_TEMP_TRIM =
		ref_trim[svc_pkg::REF_TEMP_MSB:svc_pkg::REF_TEMP_LSB];
	assign REFERENCE_OFFSET_TRIM =
		ref_trim[svc_pkg::REF_OFS_MSB:svc_pkg::REF_OFS_LSB];

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);

	property p_trap_entry;
		trap_go |=> flags_r[3] && pc_r == 16'h0000 &&
			state_r == svc_pkg::ST_PUSH_PCH;
	endproperty
	a_trap_entry: assert property (p_trap_entry)
		else $error("trap did not set flag and jump to zero");

	// Flags word is the pre-trap value with the supervisor bit forced
	property p_push_frame;
		trap_go |=> ##2 (ram_we && ram_wd == ($past(flags_r, 3) | 8'h08) &&
			ram_wa == $past(sp_r, 3) + 8'h02);
	endproperty
	a_push_frame: assert property (p_push_frame)
		else $error("flags not pushed above return PC");

	property p_return_from_interrupt_clear;
		state_r == svc_pkg::ST_POP_F |=> !flags_r[3] ##1 !flags_r[3];
	endproperty
	a_return_from_interrupt_clear: assert property (p_return_from_interrupt_clear)
		else $error("return left supervisor flag set");

	property p_reset_svc;
		in_disp && is_rst |=> pc_r == 16'h0000 && sp_r == 8'h00 &&
			state_r == svc_pkg::ST_IDLE;
	endproperty
	a_reset_svc: assert property (p_reset_svc)
		else $error("software reset did not clear PC and SP");

	property p_table_len;
		in_disp && is_tab |=> (in_loop && ram_we)[*8]
			##1 state_r == svc_pkg::ST_POP_F;
	endproperty
	a_table_len: assert property (p_table_len)
		else $error("table read did not write eight bytes");

	// First protect byte must ignore the caller pointer and touch nothing
	property p_prot_src;
		in_loop && is_prot && cnt_r == 10'h000 |->
			loop_src == PROT_SRC && !ram_we && !fl_we;
	endproperty
	a_prot_src: assert property (p_prot_src)
		else $error("protect read from wrong source");

	property p_cal_restore;
		in_disp && svc_r == svc_pkg::SVC_CAL |=>
			ref_trim == svc_pkg::REF_TRIM_5V &&
			MAIN_OSC_TRIM == svc_pkg::MAIN_OSC_5V ##1 ram_wd == 8'h00;
	endproperty
	a_cal_restore: assert property (p_cal_restore)
		else $error("calibrate did not restore trims");

	property p_ref_reset;
		$past(!RST_N) |-> ref_trim == svc_pkg::REF_TRIM_5V;
	endproperty
	a_ref_reset: assert property (p_ref_reset)
		else $error("reference trim not at factory value after reset");

	property p_csum_out;
		state_r == svc_pkg::ST_RES1 && is_csum |->
			ram_wd == csum_r[7:0] && ram_wa == PARAM_BASE + 8'h01;
	endproperty
	a_csum_out: assert property (p_csum_out)
		else $error("checksum low byte misplaced");
endmodule

// File: tb/test_supervisor_call_dispatch.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin \
	failures++; $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); \
	end end
module test_supervisor_call_dispatch;
	typedef struct packed {
		logic [9:0] idx;
		logic [31:0] wd;
		logic [31:0] exp;
		logic err;
	} svc_row_t;
	localparam logic [7:0] PB = svc_pkg::PARAM_BASE_256;
	logic SYS_CLK = 1'b0;
	logic RST_N = 1'b0;
	logic [11:0] PADDR = 12'h000;
	logic PSEL = 1'b0;
	logic PENABLE = 1'b0;
	logic PWRITE = 1'b0;
	logic [31:0] PWDATA = 32'h00000000;
	logic [31:0] PRDATA;
	logic PREADY;
	logic PSLVERR;
	logic FLASH_DIVIDER_DISABLE;
	logic [2:0] REFERENCE_TEMP_TRIM;
	logic [3:0] REFERENCE_OFFSET_TRIM;
	logic [7:0] MAIN_OSC_TRIM;
	logic [7:0] SLOW_OSC_TRIM;
	logic SVC_BUSY;
	wire logic [7:0] ref_out = {FLASH_DIVIDER_DISABLE, REFERENCE_TEMP_TRIM,
		REFERENCE_OFFSET_TRIM};
	logic [31:0] q;
	logic e;
	logic [15:0] sum;
	logic [7:0] tv [2][8];
	svc_row_t rows [11];
	int failures = 0;
	int samples_checked = 0;
	int n;
	int k;

	svc_dispatch #(.RAM_256(1'b1)) DUT (
		.SYS_CLK(SYS_CLK), .RST_N(RST_N), .PADDR(PADDR), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PWDATA(PWDATA),
		.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.FLASH_DIVIDER_DISABLE(FLASH_DIVIDER_DISABLE),
		.REFERENCE_TEMP_TRIM(REFERENCE_TEMP_TRIM),
		.REFERENCE_OFFSET_TRIM(REFERENCE_OFFSET_TRIM),
		.MAIN_OSC_TRIM(MAIN_OSC_TRIM), .SLOW_OSC_TRIM(SLOW_OSC_TRIM),
		.SVC_BUSY(SVC_BUSY)
	);

	always #20 SYS_CLK = ~SYS_CLK;

	task final_report;
		$display("failures %0d samples_checked %0d", failures, samples_checked);
		if (failures == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Master waits for pready; a stuck slave ends the run
	task apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
		int c;
		@(posedge SYS_CLK);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= w;
		PADDR <= {idx, 2'b00};
		PWDATA <= d;
		@(posedge SYS_CLK);
		PENABLE <= 1'b1;
		c = 0;
		do begin
			@(posedge SYS_CLK);
			c++;
		end while (PREADY !== 1'b1 && c < 50);
		if (c >= 50) begin
			failures++;
			final_report();
		end
		q = PRDATA;
		e = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask

	task wr(input logic [9:0] idx, input logic [31:0] d);
		apb(1'b1, idx, d);
	endtask

	task rd(input logic [9:0] idx);
		apb(1'b0, idx, 32'h00000000);
	endtask

	function automatic logic [9:0] ram(input logic [7:0] a);
		return {2'b01, a};
	endfunction

	function automatic logic [7:0] pat(input int i);
		return 8'(i * 3 + 1);
	endfunction

	task chk_ram(input logic [7:0] a, input logic [7:0] x);
		rd(ram(a));
		`CHK("ram byte", {24'h000000, x}, q)
	endtask

	// Key and return stack word go in first, then code, then the trap
	// five parameter bytes
	task svc_go(input logic [7:0] code, p2, p3, p4);
		wr(ram(PB), 32'h0000003A);
		wr(ram(PB + 8'h01), 32'h00000023);
		wr(ram(PB + 8'h02), {24'h000000, p2});
		wr(ram(PB + 8'h03), {24'h000000, p3});
		wr(ram(PB + 8'h04), {24'h000000, p4});
		wr(svc_pkg::IDX_ACC, {24'h000000, code});
		wr(svc_pkg::IDX_CTRL, 32'h00000001);
	endtask

	task wait_idle;
		int c;
		c = 0;
		do begin
			@(posedge SYS_CLK);
			c++;
		end while (SVC_BUSY !== 1'b0 && c < 3000);
		if (c >= 3000) begin
			failures++;
			final_report();
		end
	endtask

	task chk_blk(input logic z);
		for (n = 0; n < 64; n++) begin
			rd(ram(8'h80 + n[7:0]));
			`CHK("block byte", {24'h000000, z ? 8'h00 : pat(n)}, q)
		end
	endtask

	initial begin
		rows[0] = '{svc_pkg::IDX_ACC, 32'h5C, 32'h5C, 1'b0};
		rows[1] = '{svc_pkg::IDX_FLAGS, 32'h01, 32'h01, 1'b0};
		rows[2] = '{svc_pkg::IDX_PC, 32'hFFFF1234, 32'h1234, 1'b0};
		rows[3] = '{svc_pkg::IDX_SP, 32'h120, 32'h20, 1'b0};
		rows[4] = '{svc_pkg::IDX_MAIN_OSC, 32'h3C, 32'h3C, 1'b0};
		rows[5] = '{svc_pkg::IDX_SLOW_OSC, 32'h05, 32'h05, 1'b0};
		rows[6] = '{svc_pkg::IDX_REF_TRIM, 32'hB5, 32'hB5, 1'b0};
		rows[7] = '{svc_pkg::IDX_CTRL, 32'h02, 32'h00, 1'b0};
		rows[8] = '{10'h009, 32'hAA, 32'h00, 1'b1};
		rows[9] = '{10'h0EB, 32'hAA, 32'h00, 1'b1};
		rows[10] = '{10'h1F8, 32'h1AB, 32'hAB, 1'b0};
		tv[0] = '{0: svc_pkg::SILICON_ID1, 1: svc_pkg::SILICON_ID0,
			default: 8'h00};
		tv[1] = '{0: svc_pkg::REF_TRIM_3V3, 1: svc_pkg::MAIN_OSC_3V3,
			4: svc_pkg::REF_TRIM_5V, 5: svc_pkg::MAIN_OSC_5V, default: 8'h00};
		repeat (20) @(posedge SYS_CLK);
		RST_N <= 1'b1;
		@(posedge SYS_CLK);
		`CHK("ref trim", svc_pkg::REF_TRIM_5V, ref_out)
		`CHK("main trim", svc_pkg::MAIN_OSC_5V, MAIN_OSC_TRIM)
		`CHK("busy", 1'b0, SVC_BUSY)
		for (k = 0; k < 11; k++) begin
			wr(rows[k].idx, rows[k].wd);
			`CHK("write error", rows[k].err, e)
			rd(rows[k].idx);
			`CHK("read data", rows[k].exp, q)
			`CHK("read error", rows[k].err, e)
		end
		`CHK("trim fields", 8'hB5, ref_out)
		svc_go(svc_pkg::SVC_CAL, 8'h00, 8'h00, 8'h00);
		wait_idle();
		`CHK("ref trim", svc_pkg::REF_TRIM_5V, ref_out)
		`CHK("main trim", svc_pkg::MAIN_OSC_5V, MAIN_OSC_TRIM)
		`CHK("slow trim", svc_pkg::SLOW_OSC_DEF, SLOW_OSC_TRIM)
		chk_ram(PB, 8'h00);
		chk_ram(PB + 8'h01, 8'h00);
		rd(svc_pkg::IDX_FLAGS);
		`CHK("flags", 32'h01, q)
		rd(svc_pkg::IDX_PC);
		`CHK("pc", 32'h1234, q)
		chk_ram(8'h20, 8'h12);
		chk_ram(8'h21, 8'h34);
		chk_ram(8'h22, 8'h09);
		for (n = 0; n < 64; n++) wr(ram(8'h40 + n[7:0]), {24'h0, pat(n)});
		svc_go(svc_pkg::SVC_WRITE, 8'h00, 8'h40, 8'h19);
		wait_idle();
		svc_go(svc_pkg::SVC_ERASE, 8'h05, 8'h40, 8'h19);
		wait_idle();
		svc_go(svc_pkg::SVC_READ, 8'h05, 8'h80, 8'h00);
		wait_idle();
		chk_blk(1'b1);
		svc_go(svc_pkg::SVC_READ, 8'h00, 8'h80, 8'h00);
		wait_idle();
		chk_blk(1'b0);
		chk_ram(PB + 8'h01, 8'h00);
		sum = 16'h0000;
		for (n = 0; n < 64; n++) sum = sum + {8'h00, pat(n)};
		svc_go(svc_pkg::SVC_CSUM, 8'h01, 8'h00, 8'h00);
		rd(svc_pkg::IDX_FLAGS);
		`CHK("flags in call", 32'h09, q)
		rd(svc_pkg::IDX_PC);
		`CHK("pc in call", 32'h0000, q)
		`CHK("busy in call", 1'b1, SVC_BUSY)
		wr(svc_pkg::IDX_ACC, 32'h55);
		wr(svc_pkg::IDX_CTRL, 32'h01);
		wait_idle();
		rd(svc_pkg::IDX_ACC);
		`CHK("acc kept", 32'h07, q)
		chk_ram(PB, sum[15:8]);
		chk_ram(PB + 8'h01, sum[7:0]);
		for (k = 0; k < 2; k++) begin
			svc_go(svc_pkg::SVC_TABLE, 8'(k), 8'h00, 8'h00);
			wait_idle();
			for (n = 0; n < 8; n++) chk_ram(PB + 8'(n), tv[k][n]);
			rd(svc_pkg::IDX_ACC);
			`CHK("version", {24'h0, svc_pkg::VERSION_CODE}, q)
		end
		wr(ram(8'h80), 32'hC3);
		wr(ram(8'h81), 32'h3C);
		svc_go(svc_pkg::SVC_PROTECT, 8'h00, 8'h00, 8'h19);
		wait_idle();
		rd(svc_pkg::IDX_PROT);
		`CHK("protect source", 32'hC33C, q)
		svc_go(8'h05, 8'h00, 8'h00, 8'h00);
		wait_idle();
		rd(svc_pkg::IDX_STATUS);
		`CHK("error set", 1'b1, q[1])
		wr(svc_pkg::IDX_CTRL, 32'h02);
		rd(svc_pkg::IDX_STATUS);
		`CHK("error clear", 1'b0, q[1])
		svc_go(svc_pkg::SVC_RESET, 8'h00, 8'h00, 8'h00);
		n = 0;
		repeat (10) begin
			@(posedge SYS_CLK);
			if (SVC_BUSY === 1'b1) n++;
		end
		`CHK("reset length", 4, n)
		rd(svc_pkg::IDX_PC);
		`CHK("pc zero", 32'h0, q)
		rd(svc_pkg::IDX_SP);
		`CHK("sp zero", 32'h0, q)
		wr(svc_pkg::IDX_REF_TRIM, 32'h12);
		@(posedge SYS_CLK);
		RST_N <= 1'b0;
		repeat (3) @(posedge SYS_CLK);
		RST_N <= 1'b1;
		@(posedge SYS_CLK);
		`CHK("ref trim", svc_pkg::REF_TRIM_5V, ref_out)
		final_report();
	end
endmodule
